// file: hdl/serial_port_one_map.vh
// Register indices, field positions, reset values and timing counts of the first serial port
`ifndef SERIAL_PORT_ONE_MAP_VH
`define SERIAL_PORT_ONE_MAP_VH

// Register indices; byte address is four times the index
`define IDX_OPTION 8'h94
`define IDX_CTRL 8'h98
`define IDX_DATA 8'h99
`define IDX_RATE 8'hB0
`define IDX_IRQ_STAT 8'hB1
`define IDX_IRQ_MASK 8'hB2

// Control register fields
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_FILTER 5
`define CTRL_RX_EN 4
`define CTRL_TX_NINTH 3
`define CTRL_RX_NINTH 2
`define CTRL_TX_DONE 1
`define CTRL_RX_DONE 0
`define CTRL_RESET 8'h00

// Option register field
`define OPT_SINGLE_WIRE 7

// Rate register fields
`define RATE_DIV_MSB 15
`define RATE_FAST 16

// Interrupt status and mask fields
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_RESET 2'h0

// Mode encodings of the two select bits
`define MODE_SHIFT 2'h0
`define MODE_ASYNC8 2'h1
`define MODE_FIXED9 2'h2
`define MODE_VAR9 2'h3

// Tick period minus one, in system clocks; a shift-mode bit spans two ticks
`define DIV32_M1 16'h001F
`define DIV64_M1 16'h003F
`define SHIFT_TICK_M1 16'h0000

// Index of the last data bit of a byte
`define LAST_BIT 3'h7

`endif

// file: hdl/rate_tick.v
// Bit-period tick generator: one-cycle enable after a programmable count
`timescale 1ns/1ns
`default_nettype none

module rate_tick #(
	parameter W = 16
) (
	input wire clk,
	input wire rst_n,
	input wire hold,
	input wire half,
	input wire [W-1:0] period_m1,
	output wire tick
);

	reg [W-1:0] cnt;

	// While held the count waits at zero, or at half a period so the first tick lands mid-bit
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= {W{1'b0}};
		else if (hold)
			cnt <= half ? {1'b0, period_m1[W-1:1]} : {W{1'b0}};
		else if (tick)
			cnt <= {W{1'b0}};
		else
			cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
	end

	assign tick = !hold && (cnt >= period_m1);

endmodule

`default_nettype wire

// file: hdl/serial_port_one_ctrl.v
// First serial port: AHB-Lite registers, four-mode transmitter and receiver, interrupt
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_one_map.vh"

// Functional notes
// R1 - Mode 00: shift register at clock/2
// R2 - Mode 01: 8-bit async, programmable rate
// R3 - Mode 10: 9-bit async, clock/32 or /64
// R4 - Mode 11: 9-bit async, programmable rate
// R5 - 9-bit, filter set: drop ninth-bit-zero frames
// R6 - Mode 01, filter set: need valid stop
// R7 - Software keeps filter clear in shift mode
// R8 - Receive only while receive enable set
// R9 - 9-bit modes send tx ninth bit
// R10 - Capture ninth bit, or stop bit
// R11 - Tx flag: eighth bit, or stop start
// R12 - Rx flag: eighth bit, or stop sample
// R13 - Flags cleared only by software writing zero
// R14 - Data buffer: separate transmit and receive paths
// R15 - Single-wire option shares one pin
// R16 - Buffer write starts frame, LSB first
// R17 - Falling start edge, mid-bit sampling
module serial_port_one_ctrl #(
	parameter [15:0] RATE_RESET = 16'h0363
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire rxd_in,
	output reg rxd_out,
	output reg rxd_oe,
	input wire txd_in,
	output reg txd_out,
	output reg txd_oe,
	output reg irq
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_DATA = 3'h2;
	localparam [2:0] ST_NINTH = 3'h3;
	localparam [2:0] ST_STOP = 3'h4;

	// Software-visible state
	reg mode_select_high;
	reg mode_select_low;
	reg multiproc_filter;
	reg rx_enable;
	reg tx_ninth_bit;
	reg rx_ninth_bit;
	reg tx_done_flag;
	reg rx_done_flag;
	reg single_wire_option;
	reg [15:0] rate_div;
	reg rate_fast;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [7:0] rx_buf;

	// Bus data phase
	reg wr_pend;
	reg [7:0] wr_idx;

	// Transmitter
	reg [2:0] tx_state;
	reg [7:0] tx_shift;
	reg [2:0] tx_cnt;
	reg tx_line;
	reg tx_clk;
	reg tx_phase;

	// Receiver
	reg [2:0] rx_state;
	reg [7:0] rx_shift;
	reg [2:0] rx_cnt;
	reg rx_bit9;
	reg rx_clk;
	reg rx_phase;

	// Pin synchronisers
	reg rxd_s1;
	reg rxd_s2;
	reg txd_s1;
	reg txd_s2;
	reg rx_prev;

	wire [1:0] mode = {mode_select_high, mode_select_low};
	wire shift_mode = (mode == `MODE_SHIFT);
	wire nine_bit = mode_select_high;
	wire addr_ok = hsel && htrans[1] && hready;
	wire [7:0] addr_idx = haddr[9:2];
	wire wr_ctrl = wr_pend && (wr_idx == `IDX_CTRL);
	wire wr_data = wr_pend && (wr_idx == `IDX_DATA);
	wire wr_opt = wr_pend && (wr_idx == `IDX_OPTION);
	wire wr_rate = wr_pend && (wr_idx == `IDX_RATE);
	wire wr_stat = wr_pend && (wr_idx == `IDX_IRQ_STAT);
	wire wr_mask = wr_pend && (wr_idx == `IDX_IRQ_MASK);
	wire [7:0] ctrl_rd = {mode_select_high, mode_select_low, multiproc_filter, rx_enable,
		tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};

	// Bit period per mode: shift mode ticks every clock and splits each bit in two phases
	reg [15:0] period_m1;
	always @*
	begin
		case (mode)
			`MODE_SHIFT: period_m1 = `SHIFT_TICK_M1; // [R1]
			`MODE_FIXED9: period_m1 = rate_fast ? `DIV32_M1 : `DIV64_M1; // [R3]
			default: period_m1 = rate_div; // [R2] [R4]
		endcase
	end

	wire tx_tick;
	wire rx_tick;

	rate_tick #(.W(16)) u_tx_tick (
		.clk(hclk),
		.rst_n(hresetn),
		.hold(tx_state == ST_IDLE),
		.half(1'b0),
		.period_m1(period_m1),
		.tick(tx_tick)
	);

	// Outside shift mode the receive counter waits half a period so samples fall mid-bit
	rate_tick #(.W(16)) u_rx_tick (
		.clk(hclk),
		.rst_n(hresetn),
		.hold(rx_state == ST_IDLE),
		.half(!shift_mode),
		.period_m1(period_m1),
		.tick(rx_tick)
	);

	// Line source: outside shift mode the single-wire option listens on the transmit pin
	wire rx_now = (single_wire_option && !shift_mode) ? txd_s2 : rxd_s2; // [R15]

	// Events that raise the flags
	wire tx_done_evt = tx_tick && (((tx_state == ST_DATA) && (tx_cnt == `LAST_BIT)
		&& (shift_mode ? tx_phase : !nine_bit)) || (tx_state == ST_NINTH)); // [R11]
	wire rx_keep = nine_bit ? (!multiproc_filter || rx_bit9) // [R5]
		: (!multiproc_filter || rx_now); // [R6]
	wire rx_done_evt = rx_tick && (((rx_state == ST_STOP) && rx_keep && !shift_mode)
		|| (shift_mode && (rx_state == ST_DATA) && rx_phase && (rx_cnt == `LAST_BIT))); // [R12]
	wire [7:0] rx_word = rx_shift;

	// Two flops on each pin before anything looks at it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			txd_s1 <= 1'b1;
			txd_s2 <= 1'b1;
			rx_prev <= 1'b1;
		end
		else
		begin
			rxd_s1 <= rxd_in;
			rxd_s2 <= rxd_s1;
			txd_s1 <= txd_in;
			txd_s2 <= txd_s1;
			rx_prev <= rx_now;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY; writes land in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= addr_ok && hwrite;
			wr_idx <= addr_idx;
			if (addr_ok && !hwrite)
			begin
				case (addr_idx)
					`IDX_CTRL: hrdata <= {24'h000000, ctrl_rd};
					`IDX_DATA: hrdata <= {24'h000000, rx_buf}; // [R14]
					`IDX_OPTION: hrdata <= {24'h000000, single_wire_option, 7'h00};
					`IDX_RATE: hrdata <= {15'h0000, rate_fast, rate_div};
					`IDX_IRQ_STAT: hrdata <= {30'h00000000, irq_stat};
					`IDX_IRQ_MASK: hrdata <= {30'h00000000, irq_mask};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Control register; hardware set wins over a software clear in the same cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{mode_select_high, mode_select_low, multiproc_filter, rx_enable,
				tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag} <= `CTRL_RESET;
		end
		else
		begin
			if (wr_ctrl)
			begin
				mode_select_high <= hwdata[`CTRL_MODE_HI];
				mode_select_low <= hwdata[`CTRL_MODE_LO];
				multiproc_filter <= hwdata[`CTRL_FILTER];
				rx_enable <= hwdata[`CTRL_RX_EN];
				tx_ninth_bit <= hwdata[`CTRL_TX_NINTH];
			end
			// Ninth bit in 9-bit modes, stop bit in 8-bit async
			if (rx_done_evt && !shift_mode)
				rx_ninth_bit <= nine_bit ? rx_bit9 : rx_now; // [R10]
			else if (wr_ctrl)
				rx_ninth_bit <= hwdata[`CTRL_RX_NINTH];
			// Only software clears the flags
			tx_done_flag <= tx_done_evt | (wr_ctrl ? hwdata[`CTRL_TX_DONE] : tx_done_flag); // [R13] [R11]
			rx_done_flag <= rx_done_evt | (wr_ctrl ? hwdata[`CTRL_RX_DONE] : rx_done_flag); // [R13] [R12]
		end
	end

	// Own configuration and interrupt registers; status is write-one-to-clear
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			single_wire_option <= 1'b0;
			rate_div <= RATE_RESET;
			rate_fast <= 1'b0;
			irq_stat <= `IRQ_RESET;
			irq_mask <= `IRQ_RESET;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_opt)
				single_wire_option <= hwdata[`OPT_SINGLE_WIRE];
			if (wr_rate)
			begin
				rate_div <= hwdata[`RATE_DIV_MSB:0];
				rate_fast <= hwdata[`RATE_FAST];
			end
			if (wr_mask)
				irq_mask <= hwdata[1:0];
			irq_stat[`IRQ_RX] <= rx_done_evt | (irq_stat[`IRQ_RX] & ~(wr_stat & hwdata[`IRQ_RX]));
			irq_stat[`IRQ_TX] <= tx_done_evt | (irq_stat[`IRQ_TX] & ~(wr_stat & hwdata[`IRQ_TX]));
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Transmitter; a buffer write while busy is dropped rather than corrupting the frame
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_state <= ST_IDLE;
			tx_shift <= 8'h00;
			tx_cnt <= 3'h0;
			tx_line <= 1'b1;
			tx_clk <= 1'b1;
			tx_phase <= 1'b0;
		end
		else
		begin
			case (tx_state)
				ST_IDLE:
				begin
					if (wr_data) // [R14] [R16]
					begin
						tx_shift <= hwdata[7:0];
						tx_cnt <= 3'h0;
						tx_phase <= 1'b0;
						if (shift_mode)
						begin
							tx_state <= ST_DATA;
							tx_line <= hwdata[0];
							tx_clk <= 1'b0; // [R1]
						end
						else
						begin
							tx_state <= ST_START;
							tx_line <= 1'b0; // [R16]
						end
					end
				end
				ST_START:
				begin
					if (tx_tick)
					begin
						tx_state <= ST_DATA;
						tx_line <= tx_shift[0];
					end
				end
				ST_DATA:
				begin
					if (tx_tick && shift_mode && !tx_phase)
					begin
						tx_phase <= 1'b1;
						tx_clk <= 1'b1;
					end
					else if (tx_tick)
					begin
						tx_phase <= 1'b0;
						tx_shift <= {1'b0, tx_shift[7:1]};
						if (tx_cnt != `LAST_BIT)
						begin
							tx_cnt <= tx_cnt + 3'h1;
							tx_line <= tx_shift[1];
							tx_clk <= !shift_mode;
						end
						else if (shift_mode)
							tx_state <= ST_IDLE;
						else if (nine_bit)
						begin
							tx_state <= ST_NINTH;
							tx_line <= tx_ninth_bit; // [R9]
						end
						else
						begin
							tx_state <= ST_STOP;
							tx_line <= 1'b1;
						end
					end
				end
				ST_NINTH:
				begin
					if (tx_tick)
					begin
						tx_state <= ST_STOP;
						tx_line <= 1'b1;
					end
				end
				ST_STOP:
				begin
					if (tx_tick)
						tx_state <= ST_IDLE;
				end
				default:
					tx_state <= ST_IDLE;
			endcase
		end
	end

	// Receiver; dropping the enable abandons a frame in flight
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_state <= ST_IDLE;
			rx_shift <= 8'h00;
			rx_cnt <= 3'h0;
			rx_bit9 <= 1'b0;
			rx_clk <= 1'b1;
			rx_phase <= 1'b0;
			rx_buf <= 8'h00;
		end
		else if (!rx_enable) // [R8]
		begin
			rx_state <= ST_IDLE;
			rx_clk <= 1'b1;
		end
		else
		begin
			if (rx_done_evt)
				rx_buf <= shift_mode ? {rx_now, rx_word[7:1]} : rx_word; // [R14]
			case (rx_state)
				ST_IDLE:
				begin
					rx_cnt <= 3'h0;
					rx_phase <= 1'b0;
					// Shift mode clocks a byte in once the flag is clear and the line is free
					if (shift_mode && !rx_done_flag && (tx_state == ST_IDLE) && !wr_data)
					begin
						rx_state <= ST_DATA;
						rx_clk <= 1'b0; // [R1]
					end
					else if (!shift_mode && rx_prev && !rx_now)
						rx_state <= ST_START; // [R17]
				end
				ST_START:
				begin
					// A start bit gone high by mid-bit was a glitch
					if (rx_tick)
						rx_state <= rx_now ? ST_IDLE : ST_DATA; // [R17]
				end
				ST_DATA:
				begin
					if (rx_tick && shift_mode && !rx_phase)
					begin
						rx_phase <= 1'b1;
						rx_clk <= 1'b1;
					end
					else if (rx_tick)
					begin
						rx_phase <= 1'b0;
						rx_shift <= {rx_now, rx_shift[7:1]}; // [R17]
						if (rx_cnt != `LAST_BIT)
						begin
							rx_cnt <= rx_cnt + 3'h1;
							rx_clk <= !shift_mode;
						end
						else if (shift_mode)
							rx_state <= ST_IDLE;
						else
							rx_state <= nine_bit ? ST_NINTH : ST_STOP;
					end
				end
				ST_NINTH:
				begin
					if (rx_tick)
					begin
						rx_bit9 <= rx_now;
						rx_state <= ST_STOP;
					end
				end
				ST_STOP:
				begin
					if (rx_tick)
						rx_state <= ST_IDLE;
				end
				default:
					rx_state <= ST_IDLE;
			endcase
		end
	end

	// Pin drivers; shift mode puts data on the receive pin and the clock on the transmit pin
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			txd_out <= 1'b1;
			txd_oe <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
		end
		else
		begin
			txd_out <= shift_mode ? (tx_clk & rx_clk) : tx_line; // [R1]
			txd_oe <= !single_wire_option || shift_mode || (tx_state != ST_IDLE); // [R15]
			rxd_out <= tx_line;
			rxd_oe <= shift_mode && (tx_state != ST_IDLE);
		end
	end

endmodule

`default_nettype wire

// file: tb/serial_peer.sv
// Far-side serial peer: sends frames to the port and captures its frames
`timescale 1ns/1ns
`default_nettype none

module serial_peer (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	int per = 8;
	logic [8:0] got;
	initial line_out = 1'b1;

	// Start low, data LSB first, optional ninth bit, chosen stop level
	task automatic send(input logic [8:0] d, input logic nine, input logic stop);
		line_out <= 1'b0;
		repeat (per) @(posedge clk);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			line_out <= d[i];
			repeat (per) @(posedge clk);
		end
		line_out <= stop;
		repeat (per) @(posedge clk);
		line_out <= 1'b1;
	endtask

	// Waits for a start edge and samples each bit near its middle
	task automatic take(input logic nine);
		got = 9'h000;
		@(negedge line_in);
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < (nine ? 9 : 8); i++)
		begin
			repeat (per) @(posedge clk);
			got[i] = line_in;
		end
	endtask
endmodule

`default_nettype wire

// file: tb/serial_port_one_ctrl_chk.sv
// Port checker for the first serial port
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_one_map.vh"

module serial_port_one_ctrl_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic rxd_in,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	input wire logic txd_in,
	input wire logic txd_out,
	input wire logic txd_oe,
	input wire logic irq
);
	logic ap_wr, ap_rd, sw;
	logic [7:0] idx;
	logic [1:0] mode, mask;

	// Shadow of the bus phase and of the fields the checks depend on
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr <= 1'b0;
			ap_rd <= 1'b0;
			idx <= 8'h00;
			mode <= 2'h0;
			mask <= 2'h0;
			sw <= 1'b0;
		end
		else
		begin
			ap_wr <= hsel && htrans[1] && hready && hwrite;
			ap_rd <= hsel && htrans[1] && hready && !hwrite;
			idx <= haddr[9:2];
			if (ap_wr && idx == `IDX_CTRL)
				mode <= hwdata[7:6];
			if (ap_wr && idx == `IDX_IRQ_MASK)
				mask <= hwdata[1:0];
			if (ap_wr && idx == `IDX_OPTION)
				sw <= hwdata[`OPT_SINGLE_WIRE];
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Buffer write landing while an asynchronous mode is selected
	sequence data_wr;
		ap_wr && idx == `IDX_DATA && mode != `MODE_SHIFT;
	endsequence
	// One shift clock: a single low cycle, then high
	sequence shift_pulse;
		$fell(txd_out) ##1 txd_out;
	endsequence

	a_ready_high: assert property (hreadyout)
		else $error("hreadyout dropped");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_unmapped_zero: assert property (ap_rd && !(idx inside {`IDX_OPTION, `IDX_CTRL, `IDX_DATA, `IDX_RATE,
		`IDX_IRQ_STAT, `IDX_IRQ_MASK}) |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!ap_rd |-> $stable(hrdata))
		else $error("read data moved without a read");
	a_ctrl_width: assert property (ap_rd && idx == `IDX_CTRL |-> hrdata[31:8] == 24'h0)
		else $error("control read upper bits set");
	a_irq_masked: assert property ((mask == 2'h0) [*2] |-> !irq)
		else $error("irq with all sources masked");
	a_tx_start: assert property (data_wr |-> ##[1:3] !txd_out)
		else $error("no start bit after buffer write");
	a_shift_clock: assert property (mode == `MODE_SHIFT && $fell(txd_out) |-> shift_pulse)
		else $error("shift clock low too long");
	a_shift_only: assert property (mode != `MODE_SHIFT && $past(mode) != `MODE_SHIFT |-> !rxd_oe)
		else $error("data pin driven outside shift mode");
	a_pin_driven: assert property (!sw && !$past(sw) |-> txd_oe)
		else $error("transmit pin released without single wire");
endmodule

bind serial_port_one_ctrl serial_port_one_ctrl_chk i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_in(txd_in), .txd_out(txd_out), .txd_oe(txd_oe),
	.irq(irq)
);

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the first serial port
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_one_map.vh"

module tb;
	localparam logic [31:0] A_OPT = 32'h4 * `IDX_OPTION;
	localparam logic [31:0] A_CTRL = 32'h4 * `IDX_CTRL;
	localparam logic [31:0] A_DATA = 32'h4 * `IDX_DATA;
	localparam logic [31:0] A_RATE = 32'h4 * `IDX_RATE;
	localparam logic [31:0] A_STAT = 32'h4 * `IDX_IRQ_STAT;
	localparam logic [31:0] A_MASK = 32'h4 * `IDX_IRQ_MASK;
	logic hclk, hresetn, hsel, hwrite, sw, mask_m, fast_m;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, seed, rd;
	logic [7:0] sc, sb;
	logic [7:0] rxq [$];
	logic [7:0] rs [7] = '{8'h50, 8'h40, 8'h70, 8'h70, 8'hF0, 8'hF0, 8'h90};
	logic [1:0] rb [7] = '{2'b01, 2'b01, 2'b00, 2'b01, 2'b01, 2'b11, 2'b01};
	int fails, check_count;
	wire [31:0] hrdata;
	wire hreadyout, hresp, rxd_out, rxd_oe, txd_out, txd_oe, irq, peer_out;
	// Shared pins: the enabled driver wins, else the peer's line; the receive pin idles high in single-wire use
	wire rx_pin = rxd_oe ? rxd_out : (sw ? 1'b1 : peer_out);
	wire tx_pin = txd_oe ? txd_out : peer_out;

	serial_port_one_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rxd_in(rx_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
		.txd_in(tx_pin), .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq));
	serial_peer i_peer (.clk(hclk), .line_in(tx_pin), .line_out(peer_out));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Single transfer; never assumes the slave's latency
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		check(rd, e);
	endtask

	// Peer sends one frame; model predicts flag, ninth bit and buffer
	task automatic rx_case(input logic [7:0] c, input logic [1:0] nb);
		logic ok;
		logic r8;
		seed = lfsr(seed);
		bus(A_CTRL, 1'b1, {24'h0, c});
		i_peer.per = (c[7:6] == 2'h2) ? (fast_m ? 32 : 64) : 8;
		i_peer.send({nb[1], seed[7:0]}, c[7], nb[0]);
		ok = c[4] && !(c[5] && (c[7] ? !nb[1] : !nb[0]));
		r8 = c[7] ? nb[1] : nb[0];
		if (ok)
			rxq.push_back(seed[7:0]);
		repeat (4) @(posedge hclk);
		rchk(A_CTRL, {24'h0, c | (ok ? {5'h0, r8, 2'b01} : 8'h00)});
		rchk(A_DATA, {24'h0, rxq[$]});
		check({31'h0, irq}, {31'h0, ok & mask_m});
		bus(A_STAT, 1'b1, 32'h1);
	endtask

	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Hang guard, well past the few thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge hclk);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		report_and_stop;
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sw = 1'b0;
		seed = 32'hF7D9;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values; unmapped place ignores writes
		rchk(A_CTRL, {24'h0, `CTRL_RESET});
		rchk(A_STAT, 32'h0);
		rchk(A_MASK, 32'h0);
		bus(32'h4, 1'b1, 32'hFF);
		rchk(32'h4, 32'h0);
		bus(A_RATE, 1'b1, 32'h0001_0007);
		bus(A_MASK, 1'b1, 32'h3);
		mask_m = 1'b1;
		fast_m = 1'b1;
		$display("test registers done");
		// Transmit in each asynchronous mode; flag stays until written zero
		for (int m = 1; m < 4; m++)
		begin
			seed = lfsr(seed);
			sc = {m[1:0], 2'b00, m[0], 3'b000};
			i_peer.per = (m == 2) ? 32 : 8;
			bus(A_CTRL, 1'b1, {24'h0, sc});
			fork
				i_peer.take(m != 1);
				bus(A_DATA, 1'b1, {24'h0, seed[7:0]});
			join
			check({23'h0, i_peer.got}, {23'h0, m[0] & (m != 1), seed[7:0]});
			repeat (2 * i_peer.per) @(posedge hclk);
			rchk(A_CTRL, {24'h0, sc | 8'h02});
			check({31'h0, irq}, 32'h1);
			bus(A_STAT, 1'b1, 32'h2);
			bus(A_CTRL, 1'b1, {24'h0, sc});
			rchk(A_CTRL, {24'h0, sc});
			check({31'h0, irq}, 32'h0);
			$display("test transmit mode %0d done", m);
		end
		for (int i = 0; i < 7; i++)
			rx_case(rs[i], rb[i]);
		// Masked source leaves irq low
		bus(A_MASK, 1'b1, 32'h0);
		mask_m = 1'b0;
		rx_case(8'h50, 2'b01);
		// Slow fixed rate: mode 10 at one sixty-fourth of the clock
		bus(A_RATE, 1'b1, 32'h0000_0007);
		fast_m = 1'b0;
		rx_case(8'h90, 2'b11);
		$display("test receive done");
		// Transmit write leaves the received byte readable
		bus(A_CTRL, 1'b1, 32'h40);
		bus(A_DATA, 1'b1, {24'h0, ~rxq[$]});
		repeat (100) @(posedge hclk);
		rchk(A_DATA, {24'h0, rxq[$]});
		sw <= 1'b1;
		bus(A_OPT, 1'b1, 32'h80);
		rx_case(8'h50, 2'b01);
		bus(A_OPT, 1'b1, 32'h0);
		sw <= 1'b0;
		// Shift mode transmit, filter kept clear
		bus(A_CTRL, 1'b1, 32'h0);
		seed = lfsr(seed);
		fork
			for (int i = 0; i < 8; i++)
			begin
				@(posedge txd_out);
				sb[i] = rxd_out;
			end
			bus(A_DATA, 1'b1, {24'h0, seed[7:0]});
		join
		repeat (4) @(posedge hclk);
		check({24'h0, sb}, {24'h0, seed[7:0]});
		rchk(A_CTRL, 32'h2);
		$display("test shift done");
		report_and_stop;
	end
endmodule

`default_nettype wire
